/* hw/vic_top.sv */
// Vectored interrupt control: gating, priority and acceptance sequence
`timescale 1ns/1ps
`default_nettype none
`include "vic_consts.svh"
module vic_top
  import vic_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic variant_bus,
  input wire vic_mask_t evt_main,
  input wire vic_mask_t evt_alt,
  input wire vic_mask_t alt_sel,
  input wire logic req_clr_wr,
  input wire vic_mask_t req_clr_data,
  input wire logic en_wr,
  input wire vic_mask_t en_wdata,
  input wire logic iflag,
  input wire logic take_ok,
  input wire logic brk_req,
  input wire logic [15:0] pc_in,
  input wire logic [7:0] ps_in,
  input wire logic [7:0] vec_rdata,
  output vic_mask_t req_status,
  output vic_mask_t en_status,
  output logic irq_pending,
  output logic seq_busy,
  output logic push_we,
  output logic [7:0] push_data,
  output logic set_iflag,
  output logic vec_rd,
  output logic [15:0] vec_addr,
  output logic pc_load,
  output logic [15:0] pc_value
);
  vic_state_e state_reg;
  logic variant_reg;
  logic boot_reg;
  logic brk_pend_reg;
  logic [15:0] vec_reg;
  logic [15:0] pc_hold_reg;
  logic [7:0] ps_hold_reg;
  logic [7:0] vec_lo_reg;
  logic irq_pending_reg;
  logic seq_busy_reg;
  logic push_we_reg;
  logic [7:0] push_data_reg;
  logic set_iflag_reg;
  logic vec_rd_reg;
  logic [15:0] vec_addr_reg;
  logic pc_load_reg;
  logic [15:0] pc_value_reg;

  vic_mask_t req_w;
  vic_mask_t en_w;
  vic_mask_t evt_w;
  vic_mask_t alt_w;
  vic_mask_t alt_ok_w;
  vic_mask_t gated_w;
  vic_mask_t clr_ack_w;
  logic [3:0] sel_w;
  logic any_w;
  logic idle_w;
  logic accept_w;
  logic pick_brk_w;
  logic [15:0] slot_vec_w;
  logic [15:0] next_vec_w;

  ////////////////////////////////////////////////////////////////////////////
  // Source routing onto shared vectors
  // Bus line events feed two vectors, so the bus variant's three extra alternate slots add two sources
  assign alt_ok_w = variant_reg ? `VIC_ALT_BUS : `VIC_ALT_BASE; // see RL7 see RL8
  always_comb
  begin
    alt_w = evt_alt;
    alt_w[`VIC_BUS_DUP] = variant_reg ? evt_alt[`VIC_BUS_SRC] : evt_alt[`VIC_BUS_DUP];
  end
  assign evt_w = (evt_main & ~(alt_sel & alt_ok_w)) | (alt_w & alt_sel & alt_ok_w);

  genvar gi;
  generate
    for (gi = 0; gi < `VIC_NSLOT; gi = gi + 1)
    begin : g_slot
      vic_slot u_slot (
        .clk(clk),
        .rst(rst),
        .evt(evt_w[gi]),
        .clr_sw(req_clr_wr & ~req_clr_data[gi]),
        .clr_ack(clr_ack_w[gi]),
        .en_wr(en_wr),
        .en_d(en_wdata[gi]),
        .req_reg(req_w[gi]),
        .en_reg(en_w[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Gating and fixed priority, lower slot index wins
  assign gated_w = req_w & en_w & ~{`VIC_NSLOT{iflag}}; // see RL1 see RL5
  assign any_w = |gated_w;
  always_comb
  begin
    sel_w = 4'h0;
    for (int i = `VIC_NSLOT - 1; i >= 0; i--)
    begin
      if (gated_w[i])
      begin
        sel_w = 4'(i); // see RL6
      end
    end
  end

  // Break bypasses the request and enable gating and the disable flag
  assign idle_w = (state_reg == ST_IDLE);
  assign accept_w = idle_w & ~boot_reg & take_ok & (any_w | brk_pend_reg); // see RL2 see RL5
  assign pick_brk_w = ~any_w;
  assign clr_ack_w = (accept_w & ~pick_brk_w) ? vic_mask_t'(15'h0001 << sel_w) : '0; // see RL10
  assign slot_vec_w = 16'(`VIC_VEC_TOP - {11'h000, sel_w, 1'b0});
  assign next_vec_w = pick_brk_w ? `VIC_VEC_BRK : slot_vec_w; // see RL11

  ////////////////////////////////////////////////////////////////////////////
  // Acceptance sequence
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_reg <= ST_IDLE;
      variant_reg <= variant_bus;
      boot_reg <= 1'b1;
      brk_pend_reg <= 1'b0;
      vec_reg <= `VIC_VEC_RESET;
      pc_hold_reg <= 16'h0000;
      ps_hold_reg <= 8'h00;
      vec_lo_reg <= 8'h00;
      irq_pending_reg <= 1'b0;
      seq_busy_reg <= 1'b0;
      push_we_reg <= 1'b0;
      push_data_reg <= 8'h00;
      set_iflag_reg <= 1'b0;
      vec_rd_reg <= 1'b0;
      vec_addr_reg <= 16'h0000;
      pc_load_reg <= 1'b0;
      pc_value_reg <= 16'h0000;
    end
    else
    begin
      irq_pending_reg <= any_w;
      pc_load_reg <= 1'b0;
      set_iflag_reg <= 1'b0;
      brk_pend_reg <= brk_req | (brk_pend_reg & ~(accept_w & pick_brk_w));
      unique case (state_reg)
        ST_IDLE:
        begin
          seq_busy_reg <= boot_reg | accept_w;
          if (boot_reg)
          begin
            // Reset takes the top vector without stacking anything
            boot_reg <= 1'b0;
            vec_reg <= `VIC_VEC_RESET; // see RL12
            state_reg <= ST_RD_LO;
          end
          else if (accept_w)
          begin
            vec_reg <= next_vec_w;
            pc_hold_reg <= pc_in;
            ps_hold_reg <= ps_in;
            set_iflag_reg <= 1'b1; // see RL10
            push_we_reg <= 1'b1; // see RL9
            push_data_reg <= pc_in[15:8];
            state_reg <= ST_PUSH_PCL;
          end
        end
        ST_PUSH_PCL:
        begin
          push_data_reg <= pc_hold_reg[7:0];
          state_reg <= ST_PUSH_PS;
        end
        ST_PUSH_PS:
        begin
          push_data_reg <= ps_hold_reg;
          state_reg <= ST_RD_LO;
        end
        ST_RD_LO:
        begin
          push_we_reg <= 1'b0;
          vec_rd_reg <= 1'b1;
          vec_addr_reg <= vec_reg; // see RL14
          state_reg <= ST_RD_HI;
        end
        ST_RD_HI:
        begin
          vec_addr_reg <= 16'(vec_reg + 16'h0001);
          state_reg <= ST_CAP_LO;
        end
        ST_CAP_LO:
        begin
          vec_rd_reg <= 1'b0;
          vec_lo_reg <= vec_rdata;
          state_reg <= ST_LOAD;
        end
        ST_LOAD:
        begin
          pc_value_reg <= {vec_rdata, vec_lo_reg}; // see RL11 see RL14
          pc_load_reg <= 1'b1;
          seq_busy_reg <= 1'b0;
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  assign req_status = req_w;
  assign en_status = en_w;
  assign irq_pending = irq_pending_reg;
  assign seq_busy = seq_busy_reg;
  assign push_we = push_we_reg;
  assign push_data = push_data_reg;
  assign set_iflag = set_iflag_reg;
  assign vec_rd = vec_rd_reg;
  assign vec_addr = vec_addr_reg;
  assign pc_load = pc_load_reg;
  assign pc_value = pc_value_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_stack;
    push_we_reg [*3] ##1 !push_we_reg;
  endsequence
  sequence s_fetch;
    (state_reg == ST_CAP_LO) ##1 (state_reg == ST_LOAD);
  endsequence

  AST_GATE: assert property (irq_pending_reg |-> $past(|(req_w & en_w)) && !$past(iflag)) // see RL1
    else $error("pending raised without request, enable and clear flag");
  AST_MASKED: assert property (idle_w && !boot_reg && iflag && !brk_pend_reg
    |=> state_reg == ST_IDLE) // see RL5
    else $error("masked source was accepted");
  AST_BRK: assert property (idle_w && !boot_reg && take_ok && brk_pend_reg && !any_w
    |=> state_reg == ST_PUSH_PCL && vec_reg == `VIC_VEC_BRK) // see RL2
    else $error("break not taken");
  AST_NOSET: assert property ((req_w & ~$past(req_w) & ~$past(evt_w)) == '0) // see RL4
    else $error("request bit set without event");
  AST_EN: assert property (en_wr |=> en_status == $past(en_wdata)) // see RL3
    else $error("enable write lost");
  AST_PRIO: assert property (accept_w && !pick_brk_w
    |-> (gated_w & vic_mask_t'(clr_ack_w - 15'h0001)) == '0) // see RL6
    else $error("lower priority accepted first");
  AST_STACK: assert property (accept_w |=> s_stack) // see RL9
    else $error("stack push sequence wrong");
  AST_CLR: assert property (accept_w && !pick_brk_w && !(|(evt_w & clr_ack_w))
    |=> set_iflag_reg && (req_w & $past(clr_ack_w)) == '0) // see RL10
    else $error("flag not set or request not cleared");
  AST_LOAD: assert property (s_fetch |=> pc_load_reg
    && pc_value_reg == {$past(vec_rdata), $past(vec_rdata, 2)}) // see RL14
    else $error("vector bytes misassembled");
  AST_BOOT: assert property ($fell(rst) |-> ##[1:3] (vec_rd_reg
    && vec_addr_reg == `VIC_VEC_RESET)) // see RL12
    else $error("reset vector not fetched");
endmodule
`default_nettype wire

/* hw/vic_consts.svh */
// Constants for the vectored interrupt control block
// Contract
// RL1: A maskable source reaches the core only with its request bit 1, its enable bit 1 and the disable flag 0.
// RL2: The software break instruction has no request bit and no enable bit.
// RL3: Software sets and clears each enable bit by ordinary writes.
// RL4: Software may clear a request bit by a write but never set it; only the source event sets it.
// RL5: Reset and the software break are never masked; the disable flag masks every other source.
// RL6: Simultaneous pending requests are serviced one at a time, highest fixed priority first.
// RL7: The two-wire bus variant has 16 vectors shared by 23 sources.
// RL8: The base variant has 16 vectors shared by 21 sources.
// RL9: On acceptance the program counter and the status register are pushed before the handler.
// RL10: On acceptance the disable flag is set and the accepted request bit is cleared.
// RL11: On acceptance the handler address is fetched from the source's vector entry into the counter.
// RL12: Reset acts as the highest priority interrupt and fetches the top vector entry.
// RL13: Software disables interrupts, changes edge or source selection, clears the request, then re-enables.
// RL14: A vector is read low byte from the even address, high byte from the next, forming 16 bits.
`ifndef VIC_CONSTS_SVH
`define VIC_CONSTS_SVH

`define VIC_NSLOT 15
`define VIC_VEC_RESET 16'hfffc
`define VIC_VEC_BRK 16'hffdc
`define VIC_VEC_TOP 16'hfffa
`define VIC_ALT_BASE 15'h6601
`define VIC_ALT_BUS 15'h6f09
`define VIC_BUS_SRC 3
`define VIC_BUS_DUP 8

`endif

/* hw/vic_pkg.sv */
// Types shared by the vectored interrupt control block
package vic_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_PUSH_PCL,
    ST_PUSH_PS,
    ST_RD_LO,
    ST_RD_HI,
    ST_CAP_LO,
    ST_LOAD
  } vic_state_e;
  typedef logic [14:0] vic_mask_t;
endpackage

/* hw/vic_slot.sv */
// One request and enable bit pair of a maskable vector
`timescale 1ns/1ps
`default_nettype none
module vic_slot (
  input wire logic clk,
  input wire logic rst,
  input wire logic evt,
  input wire logic clr_sw,
  input wire logic clr_ack,
  input wire logic en_wr,
  input wire logic en_d,
  output logic req_reg,
  output logic en_reg
);
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      req_reg <= 1'b0;
      en_reg <= 1'b0;
    end
    else
    begin
      // Event beats a same-cycle clear; writes can only clear
      req_reg <= evt | (req_reg & ~clr_sw & ~clr_ack); // see RL4 see RL10
      if (en_wr)
      begin
        en_reg <= en_d; // see RL3
      end
    end
  end
endmodule
`default_nettype wire

/* verification/vic_cpu_model.sv */
// CPU-side partner: disable flag and vector memory with one-cycle read latency
`timescale 1ns/1ps
`default_nettype none
module vic_cpu_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic set_iflag,
  input wire logic flag_wr,
  input wire logic flag_val,
  input wire logic vec_rd,
  input wire logic [15:0] vec_addr,
  output logic iflag,
  output logic [7:0] vec_rdata
);
  always_ff @(posedge clk)
  begin
    if (rst)
      iflag <= 1'h0;
    else if (set_iflag)
      iflag <= 1'h1;
    else if (flag_wr)
      iflag <= flag_val;
  end
  // Idle bus flips every cycle so a late sample never matches
  always_ff @(posedge clk)
  begin
    if (rst)
      vec_rdata <= 8'h00;
    else if (vec_rd)
      vec_rdata <= vec_addr[7:0] ^ 8'h3c;
    else
      vec_rdata <= ~vec_rdata;
  end
endmodule
`default_nettype wire

/* verification/test_vic_top.sv */
// Self-checking bench for the vectored interrupt control block
`timescale 1ns/1ps
`default_nettype none
`include "vic_consts.svh"
module test_vic_top
  import vic_pkg::*;
;
  logic clk, rst, variant_bus, req_clr_wr, en_wr, take_ok, brk_req, flag_wr, flag_val;
  logic iflag, irq_pending, seq_busy, push_we, set_iflag, vec_rd, pc_load;
  vic_mask_t evt_main, evt_alt, alt_sel, req_clr_data, en_wdata, req_status, en_status;
  logic [15:0] pc_in, vec_addr, pc_value;
  logic [7:0] ps_in, vec_rdata, push_data;
  int errors = 0;
  int tests_run = 0;
  vic_top dut_u (.clk, .rst, .variant_bus, .evt_main, .evt_alt, .alt_sel, .req_clr_wr,
    .req_clr_data, .en_wr, .en_wdata, .iflag, .take_ok, .brk_req, .pc_in, .ps_in, .vec_rdata,
    .req_status, .en_status, .irq_pending, .seq_busy, .push_we, .push_data, .set_iflag,
    .vec_rd, .vec_addr, .pc_load, .pc_value);
  vic_cpu_model cpu_u (.clk, .rst, .set_iflag, .flag_wr, .flag_val, .vec_rd, .vec_addr,
    .iflag, .vec_rdata);
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    tests_run++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  // Memory byte is address xor 3c; vectors sit on even addresses only
  function automatic logic [15:0] vec_of(input logic [15:0] a);
    return {a[7:0] ^ 8'h3d, a[7:0] ^ 8'h3c};
  endfunction
  task automatic await(input bit on_push);
    int n;
    n = 0;
    while ((on_push ? push_we : pc_load) !== 1'b1 && n < 40)
    begin
      cyc(1);
      n++;
    end
    check(16'(n < 40), 16'h0001, "no answer");
  endtask
  task automatic evt(input vic_mask_t m, input bit alt);
    evt_main = alt ? 15'h0000 : m;
    evt_alt = alt ? m : 15'h0000;
    cyc(1);
    evt_main = 15'h0000;
    evt_alt = 15'h0000;
  endtask
  task automatic wr_en(input vic_mask_t d);
    en_wr = 1'b1;
    en_wdata = d;
    cyc(1);
    en_wr = 1'b0;
    check(16'(en_status), 16'(d), "enable");
  endtask
  task automatic clr_req(input vic_mask_t d);
    req_clr_wr = 1'b1;
    req_clr_data = d;
    cyc(1);
    req_clr_wr = 1'b0;
  endtask
  task automatic set_flag(input bit v);
    flag_wr = 1'b1;
    flag_val = v;
    cyc(1);
    flag_wr = 1'b0;
  endtask
  task automatic software_break_instruction;
    brk_req = 1'b1;
    cyc(1);
    brk_req = 1'b0;
  endtask
  task automatic quiet(input string msg);
    repeat (10)
    begin
      cyc(1);
      check(16'(seq_busy), 16'h0000, msg);
    end
  endtask
  // Take_ok drops at the end so the next acceptance waits for the caller
  task automatic serve(input logic [15:0] va, input int slot);
    pc_in = ~va;
    ps_in = va[7:0];
    take_ok = 1'b1;
    await(1'b1);
    check(16'(push_data), 16'(pc_in[15:8]), "pch");
    check(16'(set_iflag), 16'h0001, "flag set");
    if (slot >= 0)
      check(16'(req_status[slot]), 16'h0000, "req kept");
    cyc(1);
    check(16'(push_data), 16'(pc_in[7:0]), "pcl");
    cyc(1);
    check(16'(push_data), 16'(ps_in), "ps");
    await(1'b0);
    check(pc_value, vec_of(va), "vector");
    take_ok = 1'b0;
  endtask
  task automatic t_variant(input bit bus);
    rst = 1'b1;
    variant_bus = bus;
    cyc(12);
    rst = 1'b0;
    await(1'b0);
    check(pc_value, vec_of(`VIC_VEC_RESET), "reset vector");
    // Selection moves only under the flag, each move followed by a clear
    set_flag(1'b1);
    alt_sel = 15'h0109;
    clr_req(15'h0000);
    evt(15'h0009, 1'b1);
    check(16'(req_status), bus ? 16'h0109 : 16'h0001, "alternates");
    alt_sel = 15'h0000;
    clr_req(15'h0000);
    check(16'(req_status), 16'h0000, "clear all");
    set_flag(1'b0);
  endtask
  task automatic t_request;
    wr_en(15'h2b5c);
    wr_en(15'h54a3);
    wr_en(15'h0000);
    evt(15'h0010, 1'b0);
    clr_req(15'h7fff);
    check(16'(req_status), 16'h0010, "write one");
    clr_req(15'h7fef);
    check(16'(req_status), 16'h0000, "write zero");
  endtask
  task automatic t_gate;
    set_flag(1'b0);
    take_ok = 1'b1;
    evt(15'h0002, 1'b0);
    quiet("enable off");
    set_flag(1'b1);
    wr_en(15'h0002);
    quiet("flag set");
    check(16'(irq_pending), 16'h0000, "masked pending");
    software_break_instruction();
    serve(`VIC_VEC_BRK, -1);
    set_flag(1'b0);
    serve(16'hfff8, 1);
    wr_en(15'h0000);
  endtask
  task automatic t_prio;
    // Flag is still set by the last acceptance of the previous scenario
    set_flag(1'b0);
    wr_en(15'h7fff);
    evt(15'h0044, 1'b0);
    software_break_instruction();
    check(16'(irq_pending), 16'h0001, "pending");
    serve(16'hfff6, 2);
    set_flag(1'b0);
    serve(16'hffee, 6);
    serve(`VIC_VEC_BRK, -1);
    wr_en(15'h0000);
  endtask
  task automatic wrap_up;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (5000) @(posedge clk);
    errors++;
    wrap_up();
  end
  initial
  begin
    {rst, variant_bus, req_clr_wr, en_wr, take_ok, brk_req, flag_wr, flag_val} = '0;
    {evt_main, evt_alt, alt_sel, req_clr_data, en_wdata} = '0;
    pc_in = 16'h0000;
    ps_in = 8'h00;
    t_variant(1'b0);
    t_request();
    t_gate();
    t_prio();
    t_variant(1'b1);
    wrap_up();
  end
endmodule
`default_nettype wire
